// [src/ict_cycle_calc.v]
// instruction cycle count calculator for a 16-bit signal core
// assumes request fields are driven from logic on i_ref_clk
`timescale 1ns/1ps
`include "ict_defines.vh"

module ict_cycle_calc (
  input  wire                   i_ref_clk,
  input  wire                   i_rst_n,
  input  wire                   i_start,
  input  wire [`ICT_CLS_W-1:0]  i_class,
  input  wire [1:0]             i_code_loc,
  input  wire [2:0]             i_op_loc,
  input  wire [2:0]             i_dst_loc,
  input  wire                   i_op_same_code,
  input  wire                   i_dst_same_code,
  input  wire                   i_ops_same_blk,
  input  wire                   i_periph,
  input  wire                   i_cond_true,
  input  wire                   i_no_repeat_op,
  input  wire                   i_repeat_single,
  input  wire [`ICT_N_W-1:0]    i_rep_n,
  input  wire [`ICT_WS_W-1:0]   i_p_ws,
  input  wire [`ICT_WS_W-1:0]   i_d_ws,
  input  wire [`ICT_WS_W-1:0]   i_dsrc_ws,
  input  wire [`ICT_WS_W-1:0]   i_io_ws,
  input  wire                   i_acc_req,
  input  wire                   i_acc_write,
  input  wire                   i_next_read,
  input  wire                   i_ready_waits,
  output reg  [`ICT_CYC_W-1:0]  o_cycles,
  output reg                    o_done,
  output reg                    o_reject,
  output reg  [1:0]             o_discard,
  output wire                   o_exact,
  output wire [4:0]             o_acc_cycles
);

  localparam [`ICT_CYC_W-1:0] K0 = 24'h00_0000;
  localparam [`ICT_CYC_W-1:0] K1 = 24'h00_0001;
  localparam [`ICT_CYC_W-1:0] K2 = 24'h00_0002;
  localparam [`ICT_CYC_W-1:0] K3 = 24'h00_0003;
  localparam [`ICT_CYC_W-1:0] K4 = 24'h00_0004;
  localparam [`ICT_CYC_W-1:0] K5 = 24'h00_0005;
  localparam [`ICT_CYC_W-1:0] K6 = 24'h00_0006;

  // widen a wait count to the cycle width
  function [`ICT_CYC_W-1:0] wid;
    input [`ICT_WS_W-1:0] w;
    begin
      wid = {20'h0_0000, w};
    end
  endfunction

  // n times a wait count, 16 by 4 bits fits 20
  function [`ICT_CYC_W-1:0] nmul;
    input [`ICT_N_W-1:0]  n;
    input [`ICT_WS_W-1:0] w;
    reg   [19:0]          prod;
    begin
      prod = {4'h0, n} * {16'h0000, w};
      nmul = {4'h0, prod};
    end
  endfunction

  wire                  ce   = (i_code_loc == `ICT_CODE_EXTERNAL);
  wire                  csr  = (i_code_loc == `ICT_CODE_IN_SINGLE_RAM);
  wire                  repeat_single  = i_repeat_single;
  wire [`ICT_CYC_W-1:0] n    = {8'h00, i_rep_n};
  wire [`ICT_CYC_W-1:0] p    = wid(i_p_ws);
  wire [`ICT_CYC_W-1:0] d    = wid(i_d_ws);
  wire [`ICT_CYC_W-1:0] ds   = wid(i_dsrc_ws);
  wire [`ICT_CYC_W-1:0] io   = wid(i_io_ws);
  wire [`ICT_CYC_W-1:0] pe   = ce ? p : K0;
  wire [`ICT_CYC_W-1:0] nd   = nmul(i_rep_n, i_d_ws);
  wire [`ICT_CYC_W-1:0] nds  = nmul(i_rep_n, i_dsrc_ws);
  wire [`ICT_CYC_W-1:0] nio  = nmul(i_rep_n, i_io_ws);
  wire [`ICT_CYC_W-1:0] pf1  = i_periph ? K1 : K0;
  wire [`ICT_CYC_W-1:0] pfn  = i_periph ? n : K0;
  wire                  oext = (i_op_loc == `ICT_OP_EXT);
  wire                  dext = (i_dst_loc == `ICT_OP_EXT);
  wire                  oio  = (i_op_loc == `ICT_OP_MAPPED_IO_PORT);
  wire                  dio  = (i_dst_loc == `ICT_OP_MAPPED_IO_PORT);
  // sharing a block with the code only matters when code runs there
  wire                  osc  = csr && i_op_same_code &&
                               (i_op_loc == `ICT_OP_SINGLE_ACCESS_RAM);
  wire                  dsc  = csr && i_dst_same_code &&
                               (i_dst_loc == `ICT_OP_SINGLE_ACCESS_RAM);
  wire                  obk  = i_ops_same_blk &&
                               (i_op_loc == `ICT_OP_SINGLE_ACCESS_RAM) &&
                               (i_dst_loc == `ICT_OP_SINGLE_ACCESS_RAM);

  reg [`ICT_CYC_W-1:0] next_cycles;
  reg                  next_reject;
  reg [1:0]            next_discard;

  // classes that the single repeat may never target, and class 1 and 2A ops flagged by i_no_repeat_op
  always @* begin
    case (i_class)
      `ICT_CLS_3, `ICT_CLS_7B, `ICT_CLS_8, `ICT_CLS_9,
      `ICT_CLS_10, `ICT_CLS_11: begin
        next_reject = repeat_single;
      end
      `ICT_CLS_1, `ICT_CLS_2A: begin
        next_reject = repeat_single && i_no_repeat_op;
      end
      default: begin
        next_reject = 1'b0;
      end
    endcase
  end

  // cycle count per class; repeat forms include every pipeline conflict
  always @* begin
    next_cycles  = K0;
    next_discard = 2'h0;
    case (i_class)
      `ICT_CLS_1: begin
        next_cycles = (repeat_single ? n : K1) + pe;
      end
      `ICT_CLS_2A: begin
        if (oext) begin
          if (repeat_single)
            next_cycles = ce ? n + K1 + p + nd : n + nd;
          else
            next_cycles = ce ? K2 + d + p : K1 + d;
        end else if (osc) begin
          next_cycles = repeat_single ? n + K1 : K2;
        end else begin
          next_cycles = (repeat_single ? n : K1) + pe;
        end
      end
      `ICT_CLS_2B: begin
        if (oio) begin
          if (repeat_single)
            next_cycles = n + pe + nio;
          else
            next_cycles = ce ? K3 + p + io : K1 + io;
        end else begin
          next_cycles = repeat_single ? n + pe + pfn : K1 + pe + pf1;
        end
      end
      `ICT_CLS_3: begin
        next_cycles = K2 + pe + pe;
      end
      `ICT_CLS_4A: begin
        if (oext) begin
          if (repeat_single)
            next_cycles = ce ? n + n + K2 + nd + p : n + n + nd;
          else
            next_cycles = ce ? K4 + d + p : K2 + d;
        end else if (osc) begin
          next_cycles = repeat_single ? n + K2 : K2;
        end else begin
          next_cycles = (repeat_single ? n : K1) + pe;
        end
      end
      `ICT_CLS_4B: begin
        if (dio) begin
          if (repeat_single)
            next_cycles = ce ? n + n + K2 + p + nio + pfn : K2 + nio + pfn;
          else
            next_cycles = (ce ? K4 : K2) + io + pf1;
        end else begin
          next_cycles = repeat_single ? n + pe + pfn : K1 + pe + pf1;
        end
      end
      `ICT_CLS_5: begin
        if (oext) begin
          if (repeat_single)
            next_cycles = ce ? n+n+n+n + K1 + nd + nd + p : n+n+n+n - K2 + nd + nd;
          else
            next_cycles = ce ? K5 + d + d + p : K2 + d + d;
        end else if (i_op_loc == `ICT_OP_SINGLE_ACCESS_RAM) begin
          if (repeat_single)
            next_cycles = osc ? n + n + K1 : n + n - K2 + pe;
          else
            next_cycles = osc ? K3 : K1 + pe;
        end else begin
          next_cycles = (repeat_single ? n : K1) + pe;
        end
      end
      `ICT_CLS_6: begin
        if (oext) begin
          if (repeat_single)
            next_cycles = ce ? n+n+n+n + K2 + nd + nd + p + p
                             : n+n+n+n - K1 + nd + nd;
          else
            next_cycles = ce ? K6 + d + d + p + p : K3 + d + d;
        end else if (i_op_loc == `ICT_OP_SINGLE_ACCESS_RAM && repeat_single) begin
          next_cycles = osc ? n + n + K2 : n + n - K1 + pe + pe;
        end else begin
          next_cycles = (repeat_single ? n + K1 : K2) + pe + pe;
        end
      end
      `ICT_CLS_7A: begin
        if (oext) begin
          if (repeat_single)
            next_cycles = ce ? n + K2 + p + p : n + K1;
          else
            next_cycles = ce ? K3 + d + p + p : K2 + d;
        end else if (osc) begin
          next_cycles = repeat_single ? n + K2 : K3;
        end else begin
          next_cycles = (repeat_single ? n + K1 : K2) + pe + pe;
        end
      end
      `ICT_CLS_7B: begin
        if (oext)
          next_cycles = ce ? K5 + d + p + p : K3 + d;
        else
          next_cycles = osc ? K3 : K2 + pe + pe;
      end
      `ICT_CLS_8: begin
        if (i_cond_true) begin
          next_cycles  = K4 + pe + pe + pe + pe;
          next_discard = `ICT_SPEC_WORDS;
        end else begin
          next_cycles  = K2 + pe + pe;
        end
      end
      `ICT_CLS_9: begin
        next_cycles = K2 + pe + pe;
      end
      `ICT_CLS_10: begin
        if (i_cond_true) begin
          next_cycles  = K4 + pe + pe + pe;
          next_discard = `ICT_SPEC_WORDS;
        end else begin
          next_cycles  = K2 + pe;
        end
      end
      `ICT_CLS_11: begin
        next_cycles = K2 + pe;
      end
      `ICT_CLS_12: begin
        if (!repeat_single) begin
          if (dext)
            next_cycles = (ce ? K6 : K4) + d + (oext ? ds : K0) + pe + pe;
          else
            next_cycles = (dsc ? K4 : K3) + (oext ? ds : K0) + pe + pe;
        end else if (dext && oext) begin
          next_cycles = n+n+n+n + nd + nds + (ce ? K2 + p + p : K0);
        end else if (dext) begin
          next_cycles = n + n + K2 + nd + pe + pe;
        end else if (obk && dsc) begin
          next_cycles = n + n + K2;
        end else if (obk) begin
          next_cycles = n + n + pe + pe;
        end else if (dsc) begin
          next_cycles = n + K4 + (oext ? nds : K0);
        end else begin
          next_cycles = n + K2 + (oext ? nds : K0) + pe + pe;
        end
      end
      default: begin
        next_cycles = K0;
      end
    endcase
  end

  // result registers; a refused request reports zero cycles
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cycles  <= K0;
      o_done    <= 1'b0;
      o_reject  <= 1'b0;
      o_discard <= 2'h0;
    end else begin
      o_done <= i_start;
      if (i_start) begin
        o_reject  <= next_reject;
        o_cycles  <= next_reject ? K0 : next_cycles;
        o_discard <= next_reject ? 2'h0 : next_discard;
      end
    end
  end

  // discontinuity classes restart the section run
  wire discont = (i_class == `ICT_CLS_8) || (i_class == `ICT_CLS_9) ||
                 (i_class == `ICT_CLS_10) || (i_class == `ICT_CLS_11);

  ict_sect_track u_sect (
    .i_ref_clk   (i_ref_clk),
    .i_rst_n     (i_rst_n),
    .i_fetch     (i_start),
    .i_fetch_ext (ce),
    .i_discont   (discont),
    .o_exact     (o_exact)
  );

  // least length of each external bus access
  ict_ext_access u_ext (
    .i_ref_clk     (i_ref_clk),
    .i_rst_n       (i_rst_n),
    .i_acc_req     (i_acc_req),
    .i_acc_write   (i_acc_write),
    .i_next_read   (i_next_read),
    .i_ready_waits (i_ready_waits),
    .i_acc_ws      (i_d_ws),
    .o_acc_cycles  (o_acc_cycles)
  );

endmodule // ict_cycle_calc

// [src/ict_defines.vh]
// constants for the instruction cycle timing calculator
// assumes inclusion by bare name from the design files under src/
`ifndef ICT_DEFINES_VH
`define ICT_DEFINES_VH

// instruction classes
`define ICT_CLS_W          4
`define ICT_CLS_1          4'h0
`define ICT_CLS_2A         4'h1
`define ICT_CLS_2B         4'h2
`define ICT_CLS_3          4'h3
`define ICT_CLS_4A         4'h4
`define ICT_CLS_4B         4'h5
`define ICT_CLS_5          4'h6
`define ICT_CLS_6          4'h7
`define ICT_CLS_7A         4'h8
`define ICT_CLS_7B         4'h9
`define ICT_CLS_8          4'hA
`define ICT_CLS_9          4'hB
`define ICT_CLS_10         4'hC
`define ICT_CLS_11         4'hD
`define ICT_CLS_12         4'hE

// code fetch locations
`define ICT_CODE_IN_ROM         2'h0
`define ICT_CODE_IN_DUAL_RAM    2'h1
`define ICT_CODE_IN_SINGLE_RAM  2'h2
`define ICT_CODE_EXTERNAL       2'h3

// operand locations
`define ICT_OP_DUAL_ACCESS_RAM   3'h0
`define ICT_OP_SINGLE_ACCESS_RAM 3'h1
`define ICT_OP_EXT               3'h2
`define ICT_OP_ROM               3'h3
`define ICT_OP_MAPPED_REGISTER   3'h4
`define ICT_OP_MAPPED_IO_PORT    3'h5

// widths
`define ICT_CYC_W          24
`define ICT_N_W            16
`define ICT_WS_W           4

// speculative words fetched ahead of a non-delayed discontinuity
`define ICT_SPEC_WORDS     2'h2
// following fetches needed from one section for exact counts
`define ICT_SECT_RUN       3'h4

// least external access cycles
`define ICT_EXT_RD_MIN     5'h01
`define ICT_EXT_WR_MIN     5'h02
`define ICT_EXT_WR_ADJ     5'h03

`endif

// [src/ict_ext_access.v]
// least external access length for one read or write
// assumes requests come from logic on the same clock
`timescale 1ns/1ps
`include "ict_defines.vh"

module ict_ext_access (
  input  wire                   i_ref_clk,
  input  wire                   i_rst_n,
  input  wire                   i_acc_req,
  input  wire                   i_acc_write,
  input  wire                   i_next_read,
  input  wire                   i_ready_waits,
  input  wire [`ICT_WS_W-1:0]   i_acc_ws,
  output reg  [4:0]             o_acc_cycles
);

  reg        prev_read;
  reg  [4:0] next_acc_cycles;
  wire [4:0] ws5 = {1'b0, i_acc_ws};

  // zero-wait writes beside a read, before or after it, need one pad cycle
  always @* begin
    if (!i_acc_write) begin
      next_acc_cycles = `ICT_EXT_RD_MIN + ws5;
    end else if (ws5 != 5'h00) begin
      // ready-line waits cost a write one more than generator waits
      next_acc_cycles = ws5 + (i_ready_waits ? `ICT_EXT_WR_MIN : `ICT_EXT_RD_MIN);
    end else if (prev_read || i_next_read) begin
      next_acc_cycles = `ICT_EXT_WR_ADJ;
    end else begin
      next_acc_cycles = `ICT_EXT_WR_MIN;
    end
  end

  // result and last access kind
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_acc_cycles <= 5'h00;
      prev_read    <= 1'b0;
    end else if (i_acc_req) begin
      o_acc_cycles <= next_acc_cycles;
      prev_read    <= ~i_acc_write;
    end
  end

endmodule // ict_ext_access

// [src/ict_sect_track.v]
// tracks runs of fetches from one memory section
// assumes one i_fetch pulse per instruction fetched, same clock
`timescale 1ns/1ps
`include "ict_defines.vh"

module ict_sect_track (
  input  wire i_ref_clk,
  input  wire i_rst_n,
  input  wire i_fetch,
  input  wire i_fetch_ext,
  input  wire i_discont,
  output reg  o_exact
);

  reg       last_ext;
  reg [2:0] run;
  wire      same = (i_fetch_ext == last_ext);

  // a window looking back stands in for the lookahead; a branch
  // restarts the run and marks its own fetch exact; the fetches after it wait for a new run
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_ext <= 1'b0;
      run      <= 3'h0;
      o_exact  <= 1'b0;
    end else if (i_fetch) begin
      last_ext <= i_fetch_ext;
      if (i_discont) begin
        run     <= 3'h0;
        o_exact <= 1'b1;
      end else if (!same) begin
        run     <= 3'h0;
        o_exact <= 1'b0;
      end else if (run != `ICT_SECT_RUN) begin
        run     <= run + 3'h1;
        o_exact <= (run + 3'h1 == `ICT_SECT_RUN);
      end
    end
  end

endmodule // ict_sect_track

// [verif/ict_ext_mem.sv]
// far-side memory model: wait states of external program, data and io space
// assumes its mode inputs change just after a rising clock edge
`timescale 1ns/1ps
`include "ict_defines.vh"

module ict_ext_mem #(
  parameter [`ICT_WS_W-1:0] P_SLOW  = 4'h3,
  parameter [`ICT_WS_W-1:0] D_SLOW  = 4'h2,
  parameter [`ICT_WS_W-1:0] IO_SLOW = 4'h1
) (
  input  wire                 i_slow,
  input  wire                 i_use_ready,
  output reg  [`ICT_WS_W-1:0] o_p_ws,
  output reg  [`ICT_WS_W-1:0] o_d_ws,
  output reg  [`ICT_WS_W-1:0] o_io_ws,
  output reg                  o_ready_waits
);
  // slow parts stretch every access by fixed counts; fast ones answer at once
  always @* begin
    o_p_ws        = i_slow ? P_SLOW : 4'h0;
    o_d_ws        = i_slow ? D_SLOW : 4'h0;
    o_io_ws       = i_slow ? IO_SLOW : 4'h0;
    o_ready_waits = i_use_ready;
  end
endmodule // ict_ext_mem

// [verif/ict_cycle_calc_chk.sv]
// checker: count, refusal, flush and access-length relations at the ports
// assumes bind onto ict_cycle_calc; one clock, async active-low reset
`timescale 1ns/1ps
`include "ict_defines.vh"

module ict_cycle_calc_chk (
  input wire                  i_ref_clk,
  input wire                  i_rst_n,
  input wire                  i_start,
  input wire [`ICT_CLS_W-1:0] i_class,
  input wire [1:0]            i_code_loc,
  input wire                  i_cond_true,
  input wire                  i_repeat_single,
  input wire [`ICT_WS_W-1:0]  i_p_ws,
  input wire [`ICT_WS_W-1:0]  i_d_ws,
  input wire                  i_acc_req,
  input wire                  i_acc_write,
  input wire                  i_ready_waits,
  input wire [`ICT_CYC_W-1:0] o_cycles,
  input wire                  o_done,
  input wire                  o_reject,
  input wire [1:0]            o_discard,
  input wire [4:0]            o_acc_cycles
);
  // decoded request groups
  wire code_ext = (i_code_loc == `ICT_CODE_EXTERNAL);
  wire no_rpt   = (i_class == `ICT_CLS_3) || (i_class == `ICT_CLS_7B) ||
                  (i_class == `ICT_CLS_8) || (i_class == `ICT_CLS_9) ||
                  (i_class == `ICT_CLS_10) || (i_class == `ICT_CLS_11);
  wire br_taken = ((i_class == `ICT_CLS_8) || (i_class == `ICT_CLS_10)) && i_cond_true;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  done_next_a: assert property (i_start |=> o_done)
    else $error("done missing after start");
  result_hold_a: assert property (!i_start |=> $stable(o_cycles) && !o_done)
    else $error("result moved without start");
  rpt_refuse_a: assert property (i_start && i_repeat_single && no_rpt |=>
    o_reject && o_cycles == 0) else $error("repeat not refused");
  one_cycle_a: assert property (i_start && i_class == `ICT_CLS_1 && !i_repeat_single
    && !code_ext |=> o_cycles == 1) else $error("plain op count wrong");
  long_imm_a: assert property (i_start && i_class == `ICT_CLS_3 && !i_repeat_single |=>
    o_cycles == ($past(code_ext) ? 2 + 2 * $past(i_p_ws) : 2)) else $error("long imm wrong");
  flush_two_a: assert property (i_start && br_taken && !i_repeat_single |=>
    o_discard == 2'h2) else $error("taken branch kept fetched words");
  delay_slot_a: assert property (i_start && i_class == `ICT_CLS_11 && !i_repeat_single |=>
    o_discard == 2'h0 && o_cycles == 2 + ($past(code_ext) ? $past(i_p_ws) : 0))
    else $error("delayed branch count wrong");
  acc_read_a: assert property (i_acc_req && !i_acc_write |=>
    o_acc_cycles == 1 + $past(i_d_ws)) else $error("read access length wrong");
  acc_wait_a: assert property (i_acc_req && i_acc_write && i_d_ws != 0 |=>
    o_acc_cycles == $past(i_d_ws) + ($past(i_ready_waits) ? 2 : 1))
    else $error("write access length wrong");

  // main scenarios seen
  cover property (i_start && i_repeat_single && no_rpt);
  cover property (i_start && br_taken);
  cover property (i_acc_req && i_acc_write && i_ready_waits);
endmodule // ict_cycle_calc_chk

bind ict_cycle_calc ict_cycle_calc_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_class(i_class),
  .i_code_loc(i_code_loc), .i_cond_true(i_cond_true), .i_repeat_single(i_repeat_single),
  .i_p_ws(i_p_ws), .i_d_ws(i_d_ws), .i_acc_req(i_acc_req), .i_acc_write(i_acc_write),
  .i_ready_waits(i_ready_waits), .o_cycles(o_cycles), .o_done(o_done),
  .o_reject(o_reject), .o_discard(o_discard), .o_acc_cycles(o_acc_cycles));

// [verif/tb_top.sv]
// testbench: issues instruction and access requests, judges the counts
// assumes the calculator answers one cycle after each accepted start
`timescale 1ns/1ps
`include "ict_defines.vh"

// compare, count and report one value
`define CHECK_EQ(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_top;
  localparam [3:0]  P = 4'h3, D = 4'h2, IO = 4'h1;
  localparam [15:0] N = 16'h0005;
  localparam [1:0]  CR = `ICT_CODE_IN_ROM, CS = `ICT_CODE_IN_SINGLE_RAM, CE = `ICT_CODE_EXTERNAL;
  localparam [2:0]  OD = `ICT_OP_DUAL_ACCESS_RAM, OS = `ICT_OP_SINGLE_ACCESS_RAM;
  localparam [2:0]  OX = `ICT_OP_EXT, OM = `ICT_OP_MAPPED_REGISTER, OI = `ICT_OP_MAPPED_IO_PORT;

  // stimulus, all valued at time zero
  reg         i_ref_clk = 1'h0, i_rst_n = 1'h0, i_start = 1'h0;
  reg [3:0]   i_class = 4'h0;
  reg [1:0]   i_code_loc = 2'h0;
  reg [2:0]   i_op_loc = 3'h0, i_dst_loc = 3'h0;
  reg         i_op_same_code = 1'h0, i_ops_same_blk = 1'h0, i_periph = 1'h0;
  reg         i_dst_same_code = 1'h0;
  reg         i_cond_true = 1'h0, i_no_repeat_op = 1'h0, i_repeat_single = 1'h0;
  reg         i_acc_req = 1'h0, i_acc_write = 1'h0, i_next_read = 1'h0;
  reg         slow = 1'h1, use_ready = 1'h0;
  wire [3:0]  p_ws, d_ws, io_ws;
  wire        ready_waits, o_done, o_reject, o_exact;
  wire [23:0] o_cycles;
  wire [1:0]  o_discard;
  wire [4:0]  o_acc_cycles;
  int         err_count = 0, num_checks = 0;

  // 40 MHz reference clock
  always #12.5 i_ref_clk = ~i_ref_clk;

  ict_ext_mem #(.P_SLOW(P), .D_SLOW(D), .IO_SLOW(IO)) u_mem (
    .i_slow(slow), .i_use_ready(use_ready), .o_p_ws(p_ws), .o_d_ws(d_ws),
    .o_io_ws(io_ws), .o_ready_waits(ready_waits));

  // source waits share the io count so that they differ from the destination's
  ict_cycle_calc u_dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_start(i_start), .i_class(i_class),
    .i_code_loc(i_code_loc), .i_op_loc(i_op_loc), .i_dst_loc(i_dst_loc),
    .i_op_same_code(i_op_same_code), .i_dst_same_code(i_dst_same_code),
    .i_ops_same_blk(i_ops_same_blk), .i_periph(i_periph), .i_cond_true(i_cond_true),
    .i_no_repeat_op(i_no_repeat_op), .i_repeat_single(i_repeat_single), .i_rep_n(N),
    .i_p_ws(p_ws), .i_d_ws(d_ws), .i_dsrc_ws(io_ws), .i_io_ws(io_ws),
    .i_acc_req(i_acc_req), .i_acc_write(i_acc_write), .i_next_read(i_next_read),
    .i_ready_waits(ready_waits), .o_cycles(o_cycles), .o_done(o_done),
    .o_reject(o_reject), .o_discard(o_discard), .o_exact(o_exact),
    .o_acc_cycles(o_acc_cycles));

  task summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one start, bounded wait for done, then count, refusal and flush judged
  task go(input [3:0] c, input [1:0] cl, input [2:0] op, input rep,
          input [23:0] exp, input [1:0] dsc);
    int k;
    k = 0;
    @(posedge i_ref_clk);
    i_class <= c; i_code_loc <= cl; i_op_loc <= op; i_dst_loc <= op;
    i_repeat_single <= rep; i_start <= 1'h1;
    @(posedge i_ref_clk);
    i_start <= 1'h0;
    #1;
    while (o_done !== 1'h1) begin
      if (k++ == 4) begin err_count++; summarize(); end
      @(posedge i_ref_clk); #1;
    end
    `CHECK_EQ(o_cycles, exp)
    `CHECK_EQ(o_discard, dsc)
    `CHECK_EQ(o_reject, exp == 24'h0)
  endtask

  task t_single;
    logic [3:0] nr [6];
    nr = '{`ICT_CLS_3, `ICT_CLS_7B, `ICT_CLS_8, `ICT_CLS_9, `ICT_CLS_10, `ICT_CLS_11};
    go(`ICT_CLS_1, CR, OD, 0, 1, 0);
    go(`ICT_CLS_1, CE, OD, 0, 1 + P, 0);
    go(`ICT_CLS_1, CR, OD, 1, N, 0);
    go(`ICT_CLS_1, CE, OD, 1, N + P, 0);
    foreach (nr[i]) go(nr[i], CR, OD, 1, 0, 0);
    @(posedge i_ref_clk) i_no_repeat_op <= 1'h1;
    go(`ICT_CLS_1, CR, OD, 1, 0, 0);
    go(`ICT_CLS_2A, CR, OD, 1, 0, 0);
    @(posedge i_ref_clk) i_no_repeat_op <= 1'h0;
  endtask

  task t_read;
    go(`ICT_CLS_2A, CR, OX, 0, 1 + D, 0);
    go(`ICT_CLS_2A, CE, OX, 0, 2 + D + P, 0);
    @(posedge i_ref_clk) i_op_same_code <= 1'h1;
    go(`ICT_CLS_2A, CS, OS, 0, 2, 0);
    go(`ICT_CLS_2A, CS, OS, 1, N + 1, 0);
    go(`ICT_CLS_5, CS, OS, 0, 3, 0);
    go(`ICT_CLS_7A, CS, OS, 0, 3, 0);
    @(posedge i_ref_clk) i_op_same_code <= 1'h0;
    go(`ICT_CLS_2B, CR, OM, 0, 1, 0);
    @(posedge i_ref_clk) i_periph <= 1'h1;
    go(`ICT_CLS_2B, CR, OM, 0, 2, 0);
    go(`ICT_CLS_2B, CR, OM, 1, 2 * N, 0);
    go(`ICT_CLS_4B, CR, OM, 0, 2, 0);
    @(posedge i_ref_clk) i_periph <= 1'h0;
    go(`ICT_CLS_4B, CR, OI, 0, 2 + IO, 0);
    go(`ICT_CLS_3, CE, OD, 0, 2 + 2 * P, 0);
    go(`ICT_CLS_7A, CR, OX, 0, 2 + D, 0);
  endtask

  task t_write;
    go(`ICT_CLS_4A, CR, OX, 0, 2 + D, 0);
    go(`ICT_CLS_4A, CE, OX, 0, 4 + D + P, 0);
    go(`ICT_CLS_4A, CR, OX, 1, 2 * N + N * D, 0);
    go(`ICT_CLS_5, CR, OD, 0, 1, 0);
    go(`ICT_CLS_5, CR, OX, 0, 2 + 2 * D, 0);
    go(`ICT_CLS_5, CE, OX, 0, 5 + 2 * D + P, 0);
    go(`ICT_CLS_6, CR, OX, 0, 3 + 2 * D, 0);
    go(`ICT_CLS_6, CR, OD, 1, N + 1, 0);
    go(`ICT_CLS_6, CR, OS, 1, 2 * N - 1, 0);
    go(`ICT_CLS_7B, CR, OX, 0, 3 + D, 0);
    go(`ICT_CLS_7B, CE, OX, 0, 5 + D + 2 * P, 0);
  endtask

  task t_flow;
    @(posedge i_ref_clk) i_cond_true <= 1'h1;
    go(`ICT_CLS_8, CR, OD, 0, 4, 2);
    go(`ICT_CLS_8, CE, OD, 0, 4 + 4 * P, 2);
    go(`ICT_CLS_9, CE, OD, 0, 2 + 2 * P, 0);
    go(`ICT_CLS_10, CR, OD, 0, 4, 2);
    go(`ICT_CLS_10, CE, OD, 0, 4 + 3 * P, 2);
    go(`ICT_CLS_11, CE, OD, 0, 2 + P, 0);
    @(posedge i_ref_clk) i_cond_true <= 1'h0;
    go(`ICT_CLS_8, CR, OD, 0, 2, 0);
    `CHECK_EQ(o_exact, 1'h1)
    go(`ICT_CLS_9, CR, OD, 0, 2, 0);
    go(`ICT_CLS_10, CE, OD, 0, 2 + P, 0);
    go(`ICT_CLS_1, CE, OD, 0, 1 + P, 0);
    go(`ICT_CLS_11, CR, OD, 0, 2, 0);
    go(`ICT_CLS_1, CE, OD, 0, 1 + P, 0);
    `CHECK_EQ(o_exact, 1'h0)
  endtask

  task t_move;
    go(`ICT_CLS_12, CR, OD, 0, 3, 0);
    go(`ICT_CLS_12, CR, OD, 1, N + 2, 0);
    go(`ICT_CLS_12, CR, OX, 0, 4 + D + IO, 0);
    @(posedge i_ref_clk) i_ops_same_blk <= 1'h1;
    go(`ICT_CLS_12, CR, OS, 1, 2 * N, 0);
    @(posedge i_ref_clk) i_dst_same_code <= 1'h1;
    go(`ICT_CLS_12, CS, OS, 1, 2 * N + 2, 0);
    @(posedge i_ref_clk) i_ops_same_blk <= 1'h0;
    go(`ICT_CLS_12, CS, OS, 1, N + 4, 0);
    go(`ICT_CLS_12, CS, OS, 0, 4, 0);
    @(posedge i_ref_clk) i_dst_same_code <= 1'h0;
  endtask

  // one external access request, answer judged one cycle later
  task acc(input w, input nr, input [4:0] exp);
    @(posedge i_ref_clk);
    i_acc_req <= 1'h1; i_acc_write <= w; i_next_read <= nr;
    @(posedge i_ref_clk);
    i_acc_req <= 1'h0;
    #1;
    `CHECK_EQ(o_acc_cycles, exp)
  endtask

  task t_acc;
    @(posedge i_ref_clk) slow <= 1'h0;
    acc(1, 0, 2);
    acc(1, 1, 3);
    acc(0, 0, 1);
    acc(1, 0, 3);
    @(posedge i_ref_clk) slow <= 1'h1;
    acc(0, 0, 1 + D);
    @(posedge i_ref_clk) use_ready <= 1'h1;
    acc(1, 0, D + 2);
    @(posedge i_ref_clk) use_ready <= 1'h0;
    acc(1, 0, D + 1);
  endtask

  // reset for eight cycles, then every scenario in turn
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1'h1;
    t_single;
    t_read;
    t_write;
    t_flow;
    t_move;
    t_acc;
    summarize();
  end
endmodule // tb_top
